// ==== rtl/efmp_regs.svh ====
// timing and field constants for the external flash memory port
// Operation
// - drive the 16-bit data bus on writes, sample it on reads
// - drive a 21-bit word address for every transfer
// - write strobe low only while a word is written
// - output enable low only while a word is read
// - chip select low for any read or write transfer
// - flash reset copies hard reset, delayed a few clocks
// - flash reset moves only when hard reset is asserted or released, constant otherwise
// - address space covers 32 megabits of 16-bit words
// - each write strobe pulse lasts 100 ns
`ifndef EFMP_REGS_SVH
`define EFMP_REGS_SVH
`define EFMP_CLK_PERIOD_NS 10
`define EFMP_WE_LOW_NS 100
`define EFMP_ADDR_SU_NS 150
`define EFMP_DATA_HD_NS 150
`define EFMP_READ_ACC_NS 125
`define EFMP_RST_DELAY_CYC 3
`define EFMP_CYC_UP(ns) (((ns) + `EFMP_CLK_PERIOD_NS - 1) / `EFMP_CLK_PERIOD_NS)
`endif

// ==== rtl/efmp_pkg.sv ====
// types shared by the external flash memory port
package efmp_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  typedef enum logic [2:0] {
    EFMP_IDLE,
    EFMP_WR_SETUP,
    EFMP_WR_STROBE,
    EFMP_WR_HOLD,
    EFMP_RD_ACCESS,
    EFMP_RD_DONE
  } efmp_state_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic write;
  } efmp_req_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
    logic we_n;
    logic oe_n;
    logic cs_n;
  } efmp_pins_s;
endpackage

// ==== rtl/efmp_rst_delay.sv ====
// delay line that copies hard reset onto the flash reset pin
`include "efmp_regs.svh"
module efmp_rst_delay #(
  parameter int DEPTH = `EFMP_RST_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic flash_reset_n_o
);
  logic [DEPTH-1:0] pipe;
  // shift released reset through a short chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[DEPTH-2:0], 1'b1};
    end
  end
  assign flash_reset_n_o = pipe[DEPTH-1];
endmodule

// ==== rtl/efmp_port.sv ====
// external flash memory port sequencer
`include "efmp_regs.svh"
module efmp_port #(
  parameter int WE_CYC = `EFMP_CYC_UP(`EFMP_WE_LOW_NS),
  parameter int SU_CYC = `EFMP_CYC_UP(`EFMP_ADDR_SU_NS),
  parameter int HD_CYC = `EFMP_CYC_UP(`EFMP_DATA_HD_NS),
  parameter int RD_CYC = `EFMP_CYC_UP(`EFMP_READ_ACC_NS)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire efmp_pkg::efmp_req_s req_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [efmp_pkg::DATA_W-1:0] rd_data_o,
  output logic wr_done_o,
  output logic [efmp_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [efmp_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_n_o,
  input wire logic [efmp_pkg::DATA_W-1:0] mem_dq_i,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  output logic mem_cs_n_o,
  output logic flash_reset_n_o
);
  localparam int CNT_W = 8;
  efmp_pkg::efmp_state_e state;
  efmp_pkg::efmp_state_e next_state;
  efmp_pkg::efmp_pins_s pins;
  efmp_pkg::efmp_pins_s next_pins;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] load_cnt;
  logic take;
  logic cnt_done;
  logic nx_idle;
  logic nx_wr_strobe;
  logic nx_rd_access;
  logic nx_wr_phase;
  logic rd_last;
  logic wr_last;

  ////////////////////////////////////////////////////////////////////////
  // timing overview
  // one transfer at a time, taken from the user side while idle
  // write: address setup, write strobe low, data hold, then idle
  // setup and hold phases each cover the 150 ns figures, rounded up
  // strobe phase covers the 100 ns write pulse, rounded up
  // read: one access phase of the read cycle, then a closing cycle
  // the data word is captured on the last edge of the access phase
  // chip select spans every phase of a transfer, strobes inside it
  // chip select rises for at least one cycle between transfers
  // the address is loaded at the take edge and held to the next take
  // the data bus is driven only through setup, strobe and hold
  // outside writes the bus is released so the memory may drive it
  // every memory pin comes from the pins register, flash reset from the delay chain, never from decode logic
  // pins are computed from the next state, so they move with state
  // hazard: decoding pins from the current state would lag a cycle
  // hazard: a combinational strobe could glitch on the memory side
  // the phase counter loads length minus one and counts to zero
  // a phase of n cycles therefore lasts exactly n clock edges
  // the counter width covers phases up to 256 cycles long
  // a slower clock shortens the counts through the parameters only
  // ready is registered and drops on the cycle after a take
  // a request offered while ready is low is not taken, except in the first idle cycle after reset release
  // read valid and write done are one-cycle pulses
  // the read word holds until the next read replaces it
  // flash reset is a short delayed copy of the hard reset
  // it moves only after hard reset is asserted or released and is constant otherwise
  // limitation: no wait states are added for slow memories
  // limitation: byte mode is not supported, only full words
  // limitation: command sequences are left to the user side

  ////////////////////////////////////////////////////////////////////////
  // phase length to counter load
  function automatic logic [CNT_W-1:0] phase_len(input int cyc);
    phase_len = CNT_W'(cyc - 1);
  endfunction

  // true for the phases in which the port drives the data bus
  function automatic logic is_write_phase(input efmp_pkg::efmp_state_e s);
    is_write_phase = (s == efmp_pkg::EFMP_WR_SETUP) ||
                     (s == efmp_pkg::EFMP_WR_STROBE) ||
                     (s == efmp_pkg::EFMP_WR_HOLD);
  endfunction

  assign take = (state == efmp_pkg::EFMP_IDLE) && req_valid_i && !rst_i;
  assign cnt_done = (cnt == '0);

  // next state and counter
  always_comb begin
    next_state = state;
    load_cnt = cnt - CNT_W'(1);
    next_cnt = cnt_done ? cnt : load_cnt;
    unique case (state)
      efmp_pkg::EFMP_IDLE: begin
        if (take) begin
          next_state = req_i.write ? efmp_pkg::EFMP_WR_SETUP : efmp_pkg::EFMP_RD_ACCESS;
          next_cnt = req_i.write ? phase_len(SU_CYC) : phase_len(RD_CYC);
        end
      end
      efmp_pkg::EFMP_WR_SETUP: begin
        if (cnt_done) begin
          next_state = efmp_pkg::EFMP_WR_STROBE;
          next_cnt = phase_len(WE_CYC);
        end
      end
      efmp_pkg::EFMP_WR_STROBE: begin
        if (cnt_done) begin
          next_state = efmp_pkg::EFMP_WR_HOLD;
          next_cnt = phase_len(HD_CYC);
        end
      end
      efmp_pkg::EFMP_WR_HOLD: begin
        if (cnt_done) begin
          next_state = efmp_pkg::EFMP_IDLE;
        end
      end
      efmp_pkg::EFMP_RD_ACCESS: begin
        if (cnt_done) begin
          next_state = efmp_pkg::EFMP_RD_DONE;
        end
      end
      efmp_pkg::EFMP_RD_DONE: begin
        next_state = efmp_pkg::EFMP_IDLE;
      end
      default: begin
        next_state = efmp_pkg::EFMP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // decodes of the coming state
  assign nx_idle = (next_state == efmp_pkg::EFMP_IDLE);
  assign nx_wr_strobe = (next_state == efmp_pkg::EFMP_WR_STROBE);
  assign nx_rd_access = (next_state == efmp_pkg::EFMP_RD_ACCESS);
  assign nx_wr_phase = is_write_phase(next_state);

  // last edges of the access and hold phases
  assign rd_last = (state == efmp_pkg::EFMP_RD_ACCESS) && cnt_done;
  assign wr_last = (state == efmp_pkg::EFMP_WR_HOLD) && cnt_done;

  // pin values for the coming cycle
  always_comb begin
    next_pins = pins;
    if (take) begin
      next_pins.addr = req_i.addr;
      next_pins.dq_out = req_i.data;
    end
    next_pins.cs_n = nx_idle;
    next_pins.we_n = !nx_wr_strobe;
    next_pins.oe_n = !nx_rd_access;
    next_pins.dq_oe_n = !nx_wr_phase;
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= efmp_pkg::EFMP_IDLE;
      cnt <= '0;
      pins <= '{addr: '0, dq_out: '0, dq_oe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, cs_n: 1'b1};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
    end
  end

  // user side answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      wr_done_o <= 1'b0;
    end else begin
      req_ready_o <= nx_idle && !take;
      rd_valid_o <= rd_last;
      wr_done_o <= wr_last;
      if (rd_last) begin
        rd_data_o <= mem_dq_i;
      end
    end
  end

  assign mem_addr_o = pins.addr;
  assign mem_dq_o = pins.dq_out;
  assign mem_dq_oe_n_o = pins.dq_oe_n;
  assign mem_we_n_o = pins.we_n;
  assign mem_oe_n_o = pins.oe_n;
  assign mem_cs_n_o = pins.cs_n;

  // flash reset follows hard reset
  efmp_rst_delay #(
    .DEPTH(`EFMP_RST_DELAY_CYC)
  ) u_rst_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flash_reset_n_o(flash_reset_n_o)
  );
endmodule

// ==== verification/efmp_flash_model.sv ====
// behavioural word-wide flash on the far side
module efmp_flash_model (
  input wire logic clk_i,
  input wire logic [3:0] a_i,
  input wire logic [15:0] d_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic cs_n_i,
  output logic [15:0] q_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last;
  // programs finish within one clock, a fixed bound
  localparam int PROG_MAX_CYC = 1;
  // bottom boot map, sector starts at these word addresses
  localparam logic [20:0] SECT_B0 = 21'h002000;
  localparam logic [20:0] SECT_B1 = 21'h003000;
  localparam logic [20:0] SECT_B2 = 21'h004000;
  localparam logic [20:0] SECT_B3 = 21'h008000;
  localparam logic [20:0] SECT_B4 = 21'h010000;
  localparam logic [20:0] SECT_B5 = 21'h018000;
  // query structure answer: standard command set code at offset 0x17
  localparam logic [7:0] QRY_CMDSET_OFS = 8'h17;
  localparam logic [15:0] QRY_CMDSET = 16'h0002;
  initial begin
    last = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
  end
  // programming only clears bits of the whole word
  always @(posedge clk_i) begin
    last <= q_o;
    if (!cs_n_i && !we_n_i) mem[a_i] <= mem[a_i] & d_i;
  end
  // released bus shows a changing pattern
  assign q_o = (!cs_n_i && !oe_n_i) ? mem[a_i] : ~last;
endmodule

// ==== verification/efmp_port_chk.sv ====
// assertions on the external memory pins
module efmp_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_valid_o,
  input wire logic [20:0] mem_addr_o,
  input wire logic mem_dq_oe_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o,
  input wire logic mem_cs_n_o,
  input wire logic flash_reset_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ex; mem_we_n_o || mem_oe_n_o; endproperty
  a_ex: assert property (p_ex) else $error("strobe overlap");
  property p_cs; !mem_we_n_o || !mem_oe_n_o |-> !mem_cs_n_o; endproperty
  a_cs: assert property (p_cs) else $error("no select");
  property p_we; $fell(mem_we_n_o) |-> !mem_we_n_o[*8] ##1 !mem_we_n_o[*2] ##1 mem_we_n_o; endproperty
  a_we: assert property (p_we) else $error("write width");
  property p_dw; !mem_we_n_o |-> !mem_dq_oe_n_o; endproperty
  a_dw: assert property (p_dw) else $error("bus undriven");
  property p_dr; !mem_oe_n_o |-> mem_dq_oe_n_o; endproperty
  a_dr: assert property (p_dr) else $error("bus driven");
  property p_ad; !mem_cs_n_o && !$past(mem_cs_n_o) |-> $stable(mem_addr_o); endproperty
  a_ad: assert property (p_ad) else $error("addr moved");
  property p_rv; $fell(mem_oe_n_o) |-> ##13 rd_valid_o && mem_oe_n_o; endproperty
  a_rv: assert property (p_rv) else $error("read time");
  property p_rs; disable iff (1'b0) rst_i |=> !flash_reset_n_o; endproperty
  a_rs: assert property (p_rs) else $error("flash reset");
endmodule
bind efmp_port efmp_port_chk u_chk (.clk_i, .rst_i, .rd_valid_o, .mem_addr_o, .mem_dq_oe_n_o, .mem_we_n_o,
  .mem_oe_n_o, .mem_cs_n_o, .flash_reset_n_o);

// ==== verification/external_flash_memory_port_bench.sv ====
// self-checking bench for the external flash memory port
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t bad", $time); end end
module external_flash_memory_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, req_valid_i = 0, req_ready_o, rd_valid_o, wr_done_o;
  logic mem_dq_oe_n_o, mem_we_n_o, mem_oe_n_o, mem_cs_n_o, flash_reset_n_o;
  logic [15:0] rd_data_o, mem_dq_o, mem_dq_i;
  logic [20:0] mem_addr_o;
  efmp_pkg::efmp_req_s req_i = '0;
  int mismatches = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  efmp_port u_dut (.*);
  efmp_flash_model u_flash (.clk_i, .a_i(mem_addr_o[3:0]), .d_i(mem_dq_o), .we_n_i(mem_we_n_o),
    .oe_n_i(mem_oe_n_o), .cs_n_i(mem_cs_n_o), .q_o(mem_dq_i));
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one transfer with bounded waits
  task automatic xfer(input logic w, input logic [20:0] a, input logic [15:0] d);
    int n;
    for (n = 0; n < 60 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 60) begin
      mismatches++;
      results();
    end
    req_i = '{a, d, w};
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
    for (n = 0; n < 60 && (w ? wr_done_o : rd_valid_o) !== 1'b1; n++) @(negedge clk_i);
    if (n == 60) begin
      mismatches++;
      results();
    end
    `CHK(mem_addr_o, a)
    `CHK(mem_dq_oe_n_o, 1'b1)
  endtask
  // flash reset follows hard reset
  task automatic t_boot;
    `CHK(flash_reset_n_o, 1'b0)
    `CHK(mem_cs_n_o, 1'b1)
    rst_i = 0;
    repeat (8) @(negedge clk_i);
    `CHK(flash_reset_n_o, 1'b1)
  endtask
  // top word written twice, then a fresh word
  task automatic t_data;
    xfer(1, 21'h1FFFFF, 16'hA5C3);
    xfer(0, 21'h1FFFFF, 16'h0000);
    `CHK(rd_data_o, 16'hA5C3)
    xfer(1, 21'h1FFFFF, 16'h0FF0);
    xfer(0, 21'h1FFFFF, 16'h0000);
    `CHK(rd_data_o, 16'h05C0)
    xfer(0, 21'h000002, 16'h0000);
    `CHK(rd_data_o, 16'hFFFF)
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    t_boot();
    t_data();
    results();
  end
endmodule
